/* src/nsrs_host.sv */
// Contract
// (RULE1) Reset command aborts any running operation. The host refuses a reset command written while busy.
// (RULE2) Aborted program or erase leaves invalid data.
// (RULE3) Repeated reset while reset is ignored.
// (RULE4) Busy low for reset time after reset.
// (RULE5) Status byte on low eight I/O lines.
// (RULE6) Status output tracks live status continuously.
// (RULE7) Status mode holds until another command.
// (RULE8) Fresh read command after status mid-read.
// (RULE9) Bit 7 one means unprotected.
// (RULE10) Bit 6 one means sequencer ready.
// (RULE11) Bit 5 one means controller ready.
// (RULE12) Bit 0 one means program/erase failed.
// (RULE13) Reserved status bits 4..2 are ignored.
// (RULE14) Signature command returns maker then device code.
// (RULE15) Boot option loads page 0, then streams.
// (RULE16) Boot read needs no command or address.
// (RULE17) Without row read only page 0 loads.
// (RULE18) With row read pages load successively.
// (RULE19) CE high or command stops boot read.
// (RULE20) Block bad if spare marker not FFh.
// (RULE21) Read bad-block markers before any erase.
// (RULE22) Shipped valid blocks read all ones.
// (RULE23) During program only status and reset accepted.
// (RULE24) Reads default to first main half.
// (RULE25) After program/erase wait ready, check error bit.
//
// The strobed register port and the address map are this design's own decisions.
`include "nsrs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module nsrs_host #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Software register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Flash pins
    output logic nandCeN,
    output logic nandCle,
    output logic nandAle,
    output logic nandWeN,
    output logic nandReN,
    output logic nandWpN,
    output logic [7:0] nandIoOut,
    output logic nandIoOe,
    input wire logic [7:0] nandIoIn,
    input wire logic nandRdy
);
    import nsrs_pkg::*;

    localparam int PULSE = (`NSRS_T_PULSE_NS + `NSRS_CLK_NS - 1) / `NSRS_CLK_NS;
    localparam int HOLD = (`NSRS_T_HOLD_NS + `NSRS_CLK_NS - 1) / `NSRS_CLK_NS;
    localparam int WB = (`NSRS_T_WB_NS + `NSRS_CLK_NS - 1) / `NSRS_CLK_NS;
    localparam logic [3:0] SAMPLE = 4'(PULSE - 1);
    localparam logic [3:0] CYC_LAST = 4'(PULSE + HOLD - 1);
    localparam logic [3:0] WB_LAST = 4'(WB - 1);

    nsrs_state_e state_r, state_nxt;
    nsrs_op_e op_r, op_nxt;
    logic [3:0] ph_r, ph_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic pass_r, pass_nxt, post_r, post_nxt;
    logic bad_r, bad_nxt, checked_r, checked_nxt, fail_r, fail_nxt;
    logic refused_r, refused_nxt, wpRel_r, wpRel_nxt, bufSel_r, bufSel_nxt;
    logic [23:0] page_r, page_nxt;
    logic [18:0] ckBlock_r, ckBlock_nxt;
    logic [7:0] lastStat_r, lastStat_nxt, rxByte_r, rxByte_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [7:0] memRd, cmdByte, addrByte;
    logic [23:0] row;
    logic [8:0] nRead;
    logic stepEnd, samplePt, busy, eraseOk, memWr, lastRead;

    assign busy = (state_r != ST_IDLE);
    assign stepEnd = (ph_r == CYC_LAST);
    assign samplePt = (ph_r == SAMPLE);
    // Erase is only allowed on a block whose markers were read and found good.
    // (RULE21) marker check gate
    assign eraseOk = checked_r && !bad_r && (ckBlock_r == page_r[23:`NSRS_PAGE_BITS]);
    assign row = (op_r == OP_MARK) ?
        {page_r[23:`NSRS_PAGE_BITS], 4'h0, pass_r} : page_r;
    assign lastRead = (cnt_r == nRead - 9'h001);
    assign memWr = (state_r == ST_READ) && samplePt &&
        (op_r == OP_SIG || op_r == OP_PAGE || op_r == OP_BOOT);

    always_comb begin
        case (op_r)
            OP_STATUS: nRead = 9'h001;
            // (RULE14) maker then device code
            OP_SIG: nRead = 9'h002;
            OP_MARK: nRead = 9'h001;
            OP_PAGE, OP_BOOT: nRead = 9'(DEPTH);
            default: nRead = 9'h001;
        endcase
        case (op_r)
            OP_RESET: cmdByte = `NSRS_CMD_RESET;
            OP_STATUS: cmdByte = `NSRS_CMD_STATUS;
            OP_SIG: cmdByte = `NSRS_CMD_SIG;
            OP_MARK: cmdByte = `NSRS_CMD_SPARE;
            OP_ERASE: cmdByte = `NSRS_CMD_ERASE;
            // (RULE8) fresh read command
            default: cmdByte = `NSRS_CMD_READ;
        endcase
        if (post_r) begin
            cmdByte = `NSRS_CMD_STATUS;
        end
        case (cnt_r[1:0])
            2'h0: addrByte = (op_r == OP_MARK) ? `NSRS_MARK_COL : 8'h00;
            2'h1: addrByte = row[7:0];
            2'h2: addrByte = row[15:8];
            default: addrByte = row[23:16];
        endcase
    end

    // Pin drive follows the sequencer state; CE is released whenever idle.
    always_comb begin
        // (RULE19) CE high stops streaming
        nandCeN = !busy;
        nandCle = (state_r == ST_CMD) || (state_r == ST_CMD2);
        nandAle = (state_r == ST_ADDR);
        nandIoOe = nandCle || nandAle;
        nandWeN = !(nandIoOe && ph_r < 4'(PULSE));
        nandReN = !(state_r == ST_READ && ph_r < 4'(PULSE));
        nandWpN = wpRel_r;
        nandIoOut = nandAle ? addrByte :
            (state_r == ST_CMD2) ? `NSRS_CMD_CONFIRM : (nandCle ? cmdByte : 8'h00);
        regRdata = bufSel_r ? {24'h0, memRd} : rdata_r;
    end

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        ph_nxt = stepEnd ? 4'h0 : ph_r + 4'h1;
        cnt_nxt = cnt_r;
        pass_nxt = pass_r;
        post_nxt = post_r;
        bad_nxt = bad_r;
        checked_nxt = checked_r;
        fail_nxt = fail_r;
        refused_nxt = refused_r;
        wpRel_nxt = wpRel_r;
        page_nxt = page_r;
        ckBlock_nxt = ckBlock_r;
        lastStat_nxt = lastStat_r;
        rxByte_nxt = rxByte_r;
        rdata_nxt = rdata_r;
        bufSel_nxt = 1'b0;
        if (regWr && regAddr == `NSRS_REG_ADDR) begin
            page_nxt = regWdata[23:0];
        end
        if (regWr && regAddr == `NSRS_REG_CTRL) begin
            wpRel_nxt = regWdata[0];
        end
        if (regWr && regAddr == `NSRS_REG_STAT && regWdata[`NSRS_ST_REFUSED]) begin
            refused_nxt = 1'b0;
        end
        if (regRd) begin
            bufSel_nxt = (regAddr >= `NSRS_BUF_BASE);
            case (regAddr)
                `NSRS_REG_ADDR: rdata_nxt = {8'h00, page_r};
                `NSRS_REG_CTRL: rdata_nxt = {31'h0, wpRel_r};
                `NSRS_REG_STAT: rdata_nxt = {16'h0, lastStat_r, 3'h0, refused_r,
                    fail_r, checked_r, bad_r, busy};
                default: rdata_nxt = 32'h0;
            endcase
        end
        case (state_r)
            ST_IDLE: begin
                ph_nxt = 4'h0;
                if (regWr && regAddr == `NSRS_REG_CMD) begin
                    op_nxt = nsrs_op_e'(regWdata[2:0]);
                    cnt_nxt = 9'h000;
                    pass_nxt = 1'b0;
                    post_nxt = 1'b0;
                    if (regWdata[2:0] > 3'(OP_BOOT) ||
                        (regWdata[2:0] == 3'(OP_ERASE) && !eraseOk)) begin
                        refused_nxt = 1'b1;
                    end else if (regWdata[2:0] == 3'(OP_BOOT)) begin
                        // (RULE16) boot needs no command
                        state_nxt = ST_WAIT;
                    end else begin
                        state_nxt = ST_CMD;
                    end
                end
            end
            ST_CMD: begin
                if (stepEnd) begin
                    // Erase skips the column byte, but its status read must start at zero.
                    cnt_nxt = (op_r == OP_ERASE && !post_r) ? 9'h001 : 9'h000;
                    if (post_r || op_r == OP_STATUS) begin
                        state_nxt = ST_READ;
                    end else if (op_r == OP_RESET) begin
                        state_nxt = ST_WAIT;
                    end else begin
                        state_nxt = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (stepEnd) begin
                    cnt_nxt = cnt_r + 9'h001;
                    if (op_r == OP_SIG) begin
                        cnt_nxt = 9'h000;
                        state_nxt = ST_READ;
                    end else if (cnt_r[1:0] == 2'h3) begin
                        cnt_nxt = 9'h000;
                        state_nxt = (op_r == OP_ERASE) ? ST_CMD2 : ST_WAIT;
                    end
                end
            end
            ST_CMD2: begin
                if (stepEnd) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Ready is ignored until the flash has had time to pull it low.
                ph_nxt = (ph_r == WB_LAST) ? ph_r : ph_r + 4'h1;
                // (RULE4) wait out reset busy
                if (ph_r == WB_LAST && nandRdy) begin
                    ph_nxt = 4'h0;
                    if (op_r == OP_RESET) begin
                        state_nxt = ST_IDLE;
                    end else if (op_r == OP_ERASE) begin
                        // (RULE25) status after erase
                        post_nxt = 1'b1;
                        state_nxt = ST_CMD;
                    end else begin
                        state_nxt = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (samplePt) begin
                    rxByte_nxt = nandIoIn;
                    if (op_r == OP_STATUS || post_r) begin
                        // (RULE13) drop reserved bits
                        lastStat_nxt = nandIoIn & `NSRS_SR_MASK;
                    end
                    if (post_r) begin
                        // (RULE12) latch failure bit
                        fail_nxt = nandIoIn[`NSRS_SR_FAIL];
                    end
                end
                if (stepEnd) begin
                    cnt_nxt = cnt_r + 9'h001;
                    if (lastRead) begin
                        cnt_nxt = 9'h000;
                        state_nxt = ST_IDLE;
                        // (RULE20) marker on two pages
                        if (op_r == OP_MARK) begin
                            if (!pass_r && rxByte_r == `NSRS_ERASED) begin
                                pass_nxt = 1'b1;
                                state_nxt = ST_CMD;
                            end else begin
                                bad_nxt = (rxByte_r != `NSRS_ERASED);
                                checked_nxt = 1'b1;
                                ckBlock_nxt = page_r[23:`NSRS_PAGE_BITS];
                            end
                        end
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (regWr && regAddr == `NSRS_REG_CMD && busy) begin
            refused_nxt = 1'b1;
        end
        if (regWr && regAddr == `NSRS_REG_ADDR) begin
            checked_nxt = (checked_nxt &&
                regWdata[23:`NSRS_PAGE_BITS] == ckBlock_nxt);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            op_r <= OP_RESET;
            ph_r <= 4'h0;
            cnt_r <= 9'h000;
            pass_r <= 1'b0;
            post_r <= 1'b0;
            bad_r <= 1'b0;
            checked_r <= 1'b0;
            fail_r <= 1'b0;
            refused_r <= 1'b0;
            wpRel_r <= 1'b0;
            bufSel_r <= 1'b0;
            page_r <= 24'h000000;
            ckBlock_r <= 19'h00000;
            lastStat_r <= 8'h00;
            rxByte_r <= 8'h00;
            rdata_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            ph_r <= ph_nxt;
            cnt_r <= cnt_nxt;
            pass_r <= pass_nxt;
            post_r <= post_nxt;
            bad_r <= bad_nxt;
            checked_r <= checked_nxt;
            fail_r <= fail_nxt;
            refused_r <= refused_nxt;
            wpRel_r <= wpRel_nxt;
            bufSel_r <= bufSel_nxt;
            page_r <= page_nxt;
            ckBlock_r <= ckBlock_nxt;
            lastStat_r <= lastStat_nxt;
            rxByte_r <= rxByte_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    nsrs_buf_mem #(.W(8), .D(DEPTH), .AW(AW)) u_nsrs_buf_mem (
        .clk(mclk),
        .rst_n(rst_n),
        .wrEn(memWr),
        .wrAddr(cnt_r[AW-1:0]),
        .wrData(nandIoIn),
        .rdAddr(regAddr[AW+1:2]),
        .rdData(memRd)
    );

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_strobe_excl: assert property (!(!nandWeN && !nandReN) && !(nandCle && nandAle))
        else $error("write and read strobes or latches overlap");
    a_we_width: assert property ($fell(nandWeN) |=> !nandWeN ##1 nandWeN)
        else $error("write strobe width wrong");
    // (RULE4) ready gate
    a_wait_ready: assert property (state_r == ST_WAIT && state_nxt != ST_WAIT // (RULE4)
        |-> nandRdy && ph_r == WB_LAST) else $error("left wait before ready");
    // (RULE21) erase gate
    a_erase_gated: assert property ($rose(nandCle) && nandIoOut == `NSRS_CMD_ERASE // (RULE21)
        |-> eraseOk) else $error("erase issued without marker check");
    // (RULE16) no command cycles
    a_boot_quiet: assert property (op_r == OP_BOOT && busy |-> !nandCle && !nandAle) // (RULE16)
        else $error("boot read drove a command");
    // (RULE20) bad marker
    a_bad_mark: assert property (state_r == ST_READ && op_r == OP_MARK && stepEnd // (RULE20)
        && rxByte_r != `NSRS_ERASED |=> bad_r && checked_r)
        else $error("bad marker not flagged");
    // (RULE12) failure flag
    a_fail_latch: assert property (state_r == ST_READ && post_r && samplePt // (RULE12)
        |=> fail_r == $past(nandIoIn[`NSRS_SR_FAIL])) else $error("fail bit not taken");
    a_refuse_busy: assert property (regWr && regAddr == `NSRS_REG_CMD && busy
        |=> refused_r) else $error("busy command not refused");
    // (RULE19) CE released
    a_ce_idle: assert property (state_r == ST_READ && stepEnd && lastRead // (RULE19)
        && op_r != OP_MARK |=> nandCeN) else $error("CE held after read");
    a_rd_latency: assert property (regRd && regAddr == `NSRS_REG_STAT
        |=> regRdata[`NSRS_ST_BUSY] == $past(busy)) else $error("status read wrong");
endmodule : nsrs_host

`default_nettype wire

/* common/nsrs_consts.svh */
`ifndef NSRS_CONSTS_SVH
`define NSRS_CONSTS_SVH

// Software register map (byte addresses).
`define NSRS_REG_CMD 8'h00
`define NSRS_REG_ADDR 8'h04
`define NSRS_REG_STAT 8'h08
`define NSRS_REG_CTRL 8'h0c
`define NSRS_BUF_BASE 8'h80

// Status word fields.
`define NSRS_ST_BUSY 0
`define NSRS_ST_BAD 1
`define NSRS_ST_CHECKED 2
`define NSRS_ST_FAIL 3
`define NSRS_ST_REFUSED 4

// Flash command bytes.
`define NSRS_CMD_RESET 8'hff
`define NSRS_CMD_STATUS 8'h70
`define NSRS_CMD_SIG 8'h90
`define NSRS_CMD_SPARE 8'h50
`define NSRS_CMD_READ 8'h00
`define NSRS_CMD_ERASE 8'h60
`define NSRS_CMD_CONFIRM 8'hd0

// Flash status byte fields; bits 4..1 are masked off.
`define NSRS_SR_WP 7
`define NSRS_SR_SEQ 6
`define NSRS_SR_CTL 5
`define NSRS_SR_FAIL 0
`define NSRS_SR_MASK 8'he1

// Bad-block marker: sixth spare byte, erased value.
`define NSRS_MARK_COL 8'h05
`define NSRS_ERASED 8'hff
`define NSRS_PAGE_BITS 5

// Bus timing.
`define NSRS_CLK_NS 25
`define NSRS_T_PULSE_NS 40
`define NSRS_T_HOLD_NS 20
`define NSRS_T_WB_NS 100

`endif

/* common/nsrs_pkg.sv */
package nsrs_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_CMD = 6'h02,
        ST_ADDR = 6'h04,
        ST_CMD2 = 6'h08,
        ST_WAIT = 6'h10,
        ST_READ = 6'h20
    } nsrs_state_e;

    typedef enum logic [2:0] {
        OP_RESET = 3'h0,
        OP_STATUS = 3'h1,
        OP_SIG = 3'h2,
        OP_MARK = 3'h3,
        OP_ERASE = 3'h4,
        OP_PAGE = 3'h5,
        OP_BOOT = 3'h6
    } nsrs_op_e;

endpackage : nsrs_pkg

/* src/nsrs_buf_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module nsrs_buf_mem #(
    parameter int W = 8,
    parameter int D = 32,
    parameter int AW = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [W-1:0] wrData,
    // Read side
    input wire logic [AW-1:0] rdAddr,
    output logic [W-1:0] rdData
);
    logic [W-1:0] mem [D];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : nsrs_buf_mem

`default_nettype wire

/* bench/nsrs_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

module nsrs_flash_model #(
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value.
    parameter logic [7:0] DEVID = 8'h5a, // Arbitrary value.
    parameter int PAGE = 4,
    parameter int BADBLK = 3,
    parameter int FAILBLK = 2,
    parameter bit SEQROW = 0
) (
    // Host-driven pins
    input wire logic ceN,
    input wire logic cle,
    input wire logic ale,
    input wire logic weN,
    input wire logic reN,
    input wire logic wpN,
    input wire logic [7:0] ioOut,
    input wire logic ioOe,
    // Device-driven pins
    output logic [7:0] ioIn,
    output logic rdy
);
    typedef enum logic [2:0] {M_IDLE, M_STAT, M_SIG, M_READ, M_BOOT, M_ERASE} nsrs_mode_e;
    nsrs_mode_e mode = M_BOOT;
    int busy = 20;
    int nAddr = 0;
    int col = 0;
    logic [23:0] row = '0;
    logic [7:0] colAddr = '0;
    logic [7:0] last = '0;
    logic [7:0] data;
    logic spare = 0;
    logic failed = 0;
    logic erasing = 0;
    logic inReset = 0;

    assign rdy = (busy == 0);
    // Released bus shows the inverse of its last byte, so a stale sample never matches.
    assign ioIn = (!ceN && !reN && mode != M_IDLE && mode != M_ERASE) ? data : ~last;

    always begin
        #25;
        if (busy > 0) begin
            busy--;
            // error bit set on failed erase
            if (busy == 0 && erasing) begin
                failed = (row[23:5] == FAILBLK);
                erasing = 0;
            end
        end
    end

    always @* begin
        case (mode)
            M_STAT: data = {wpN, rdy, rdy, 3'b101, 1'b1, failed};
            M_SIG: data = (col[0]) ? DEVID : MAKER;
            default: if (spare) data = (row[23:5] == BADBLK && row[4:0] == 1 && colAddr + col == 5)
                    ? 8'h00 : 8'hff;
                else data = (row[23:5] == 0) ? 8'h10 + 8'(col) + row[7:0] : 8'hff;
        endcase
    end

    // A byte counts only while the host says that it drives the bus.
    always @(posedge weN) if (ioOe) begin
        if (!ceN && cle) begin
            // abort, ignore repeat, busy by running op
            if (ioOut == 8'hff && !inReset) begin
                busy = erasing ? 40 : 8;
                erasing = 0;
                failed = 0;
                mode = M_IDLE;
                inReset = 1;
            end else if (ioOut == 8'h70) mode = M_STAT;
            else if (busy == 0 && ioOut != 8'hff) begin
                // any command ends boot, pointer to main area
                inReset = 0;
                nAddr = 0;
                col = 0;
                case (ioOut)
                    8'h90: mode = M_SIG;
                    8'h00, 8'h50: begin
                        mode = M_READ;
                        spare = ioOut[4];
                    end
                    8'h60: mode = M_ERASE;
                    8'hd0: if (mode == M_ERASE && wpN) begin
                        erasing = 1;
                        busy = 40;
                    end
                    default: ;
                endcase
            end
        end else if (!ceN && ale) begin
            if (mode == M_ERASE) row[8*nAddr +: 8] = ioOut;
            else if (nAddr == 0) colAddr = ioOut;
            else row[8*(nAddr-1) +: 8] = ioOut;
            nAddr++;
            if (mode == M_READ && nAddr == 4) busy = 20;
        end
    end

    always @(posedge reN) if (!ceN) begin
        last = data;
        col++;
        // next page only with row read built in
        if (col == PAGE && SEQROW && mode == M_BOOT) begin
            col = 0;
            row++;
            busy = 20;
        end
    end

    // chip enable high stops the stream
    always @(posedge ceN) if (mode == M_BOOT && col > 0) mode = M_IDLE;
endmodule : nsrs_flash_model

`default_nettype wire

/* bench/nsrs_host_tb.sv */
`include "nsrs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module nsrs_host_tb;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
    localparam logic [7:0] DEVID = 8'h5a; // Arbitrary value.
    logic mclk, rst_n, regWr, regRd, nandCeN, nandCle, nandAle, nandWeN, nandReN;
    logic nandWpN, nandIoOe, nandRdy;
    logic [7:0] regAddr, nandIoOut, nandIoIn;
    logic [31:0] regWdata, regRdata, rd;
    int miscompares = 0;
    int comparisons = 0;

    nsrs_host #(.DEPTH(4), .AW(2)) u_nsrs_host (.mclk(mclk), .rst_n(rst_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .nandCeN(nandCeN), .nandCle(nandCle), .nandAle(nandAle),
        .nandWeN(nandWeN), .nandReN(nandReN), .nandWpN(nandWpN), .nandIoOut(nandIoOut),
        .nandIoOe(nandIoOe), .nandIoIn(nandIoIn), .nandRdy(nandRdy));
    nsrs_flash_model #(.MAKER(MAKER), .DEVID(DEVID)) u_nsrs_flash_model (.ceN(nandCeN),
        .cle(nandCle), .ale(nandAle), .weN(nandWeN), .reN(nandReN), .wpN(nandWpN),
        .ioOut(nandIoOut), .ioOe(nandIoOe), .ioIn(nandIoIn), .rdy(nandRdy));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [7:0] a);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 rd = regRdata;
    endtask : regRead

    // Poll until the busy flag drops.
    task automatic waitIdle;
        for (int i = 0; i < 500; i++) begin
            regRead(`NSRS_REG_STAT);
            if (rd[0] === 1'b0) return;
        end
        miscompares++;
        test_done();
    endtask : waitIdle

    // Start an operation and wait for it to finish.
    task automatic runOp(input logic [31:0] op);
        regWrite(`NSRS_REG_CMD, op);
        waitIdle();
    endtask : runOp

    task automatic checkBuf(input logic [7:0] first, input bit step);
        for (int i = 0; i < 4; i++) begin
            regRead(`NSRS_BUF_BASE + 8'(4 * i));
            check(rd, {24'h0, first + (step ? 8'(i) : 8'h00)});
        end
    endtask : checkBuf

    task automatic t_boot_sig_status;
        runOp(32'h6);
        checkBuf(8'h10, 1);
        runOp(32'h2);
        regRead(`NSRS_BUF_BASE);
        check(rd[7:0], MAKER);
        regRead(`NSRS_BUF_BASE + 8'h04);
        check(rd[7:0], DEVID);
        runOp(32'h1);
        check(rd[15:8], 8'h60);
        regWrite(`NSRS_REG_CTRL, 32'h1);
        runOp(32'h1);
        check(rd[15:8], 8'he0);
    endtask : t_boot_sig_status

    task automatic t_bad_block;
        regWrite(`NSRS_REG_ADDR, 32'h3 << 5);
        runOp(32'h3);
        check(rd[2:0], 3'h6);
        runOp(32'h4);
        check(rd[4:0], 5'h16);
        regWrite(`NSRS_REG_STAT, 32'h10);
        regRead(`NSRS_REG_STAT);
        check(rd[4], 1'b0);
        // A command written while the first one still runs must be refused.
        regWrite(`NSRS_REG_CMD, 32'h1);
        regWrite(`NSRS_REG_CMD, 32'h1);
        waitIdle();
        check(rd[4], 1'b1);
        regWrite(`NSRS_REG_STAT, 32'h10);
    endtask : t_bad_block

    task automatic t_erase(input logic [31:0] blk, input logic fail);
        regWrite(`NSRS_REG_ADDR, blk << 5);
        runOp(32'h3);
        check(rd[2:0], 3'h4);
        runOp(32'h4);
        check(rd[15:8], {7'h70, fail});
        check(rd[3], fail);
    endtask : t_erase

    task automatic t_reads;
        runOp(32'h1);
        regWrite(`NSRS_REG_ADDR, 32'h1);
        runOp(32'h5);
        checkBuf(8'h11, 1);
        regWrite(`NSRS_REG_ADDR, 32'h1 << 5);
        runOp(32'h5);
        checkBuf(8'hff, 0);
        runOp(32'h0);
        runOp(32'h0);
        check(rd[4:0], 5'h0);
        regRead(8'h40);
        check(rd, 32'h0);
    endtask : t_reads

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_boot_sig_status();
        t_bad_block();
        t_erase(32'h2, 1'b1);
        t_erase(32'h1, 1'b0);
        t_reads();
        test_done();
    end
endmodule : nsrs_host_tb

`default_nettype wire
